// file: src/see_pkg.sv
// Constants, state encoding and behaviour notes for the serial EEPROM bus slave.
// Notes on behaviour
// - The device answers only when the three chip-select bits of the control byte equal the three straps.
// - The data pin is open drain: the device only pulls it low or releases it, never drives it high.
// - Ordinary data bits change only while the clock is low; changes with the clock high mean start or stop.
// - With write protect high no array write happens, while reads work as usual.
// - With write protect low (pulled down when open) reads and writes cover the whole 0000-1FFF range.
// - The self-timed write cycle of a byte or a page ends within at most 5 ms.
// - When sending, the device holds its data output at least 300 ns after each falling clock edge.
// - Pulses of up to 50 ns on the clock and data inputs are filtered out.
// - When sending, the next bit is valid within 900 ns (3500 ns at low supply) after the clock falls.
// - The first byte after a start is a 4-bit type code, three chip-select bits and a read bit (1 = read).
// - Data falling with clock high is a start; data rising with clock high is a stop.
// - Write protect is sampled at the stop ending a write command and later changes have no effect.
// - A stop after a write starts the write cycle, and no acknowledge is given until it ends.
`default_nettype none
package see_pkg;
  localparam int CLK_NS = 100;
  localparam int SPK_NS = 50;
  localparam int HOLD_NS = 300;
  localparam int VALID_NS = 900;
  localparam int VALID_SLOW_NS = 3500;
  localparam int IDLE_NS = 1300;
  localparam int IDLE_SLOW_NS = 4700;
  localparam int TWC_MS = 5;
  localparam logic [3:0] SPK_CYC = 4'((SPK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] VALID_CYC = 4'(VALID_NS / CLK_NS);
  localparam int TWC_CYC = TWC_MS * 1000000 / CLK_NS;
  localparam int ADDR_W = 13;
  localparam logic [12:0] PTR_RST = 13'h0000;
  localparam logic [3:0] BIT_LAST = 4'h8;
  typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_ADRH, ST_ADRL, ST_WDAT, ST_RDAT, ST_IGN} see_st_e;
endpackage
`default_nettype wire

// file: src/see_slave.sv
// Two-wire serial EEPROM slave: write buffer FIFO and the bus front end with array.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Write buffer FIFO
// ----------------------------------------------------------------
module see_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } see_fifo_s;

  see_fifo_s q_ff;
  see_fifo_s nxt_q;
  logic [W-1:0] mem_ff [D];
  logic push;
  logic pop;

  assign o_in_ready = (q_ff.cnt != (AW+1)'(D));
  assign o_out_valid = (q_ff.cnt != '0);
  assign o_out_data = mem_ff[q_ff.rp];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_comb begin
    nxt_q = q_ff;
    if (push) begin
      nxt_q.wp = (q_ff.wp == AW'(D - 1)) ? '0 : q_ff.wp + AW'(1);
    end
    if (pop) begin
      nxt_q.rp = (q_ff.rp == AW'(D - 1)) ? '0 : q_ff.rp + AW'(1);
    end
    if (push && !pop) begin
      nxt_q.cnt = q_ff.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_q.cnt = q_ff.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[q_ff.wp] <= i_in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// Bus slave with array
// ----------------------------------------------------------------
module see_slave #(
  parameter int TWC_CYC = see_pkg::TWC_CYC,
  // Device-type code: value is arbitrary, set it to the part's code.
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int BUF_DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [2:0] i_chip_address_straps,
  input wire logic i_wp,
  output logic o_busy
);
  localparam int TW = $clog2(TWC_CYC + 1);
  localparam int MW = see_pkg::ADDR_W;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [2:0] str1;
    logic [2:0] str2;
    logic wp1;
    logic wp2;
    logic fscl;
    logic fsda;
    logic pscl;
    logic psda;
    logic [3:0] cscl;
    logic [3:0] csda;
    see_pkg::see_st_e st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic ack_ph;
    logic mack;
    logic [MW-1:0] ptr;
    logic [MW-1:0] wad;
    logic wp_l;
    logic [3:0] hcnt;
    logic pend;
    logic oe;
    logic sdo;
    logic drain;
    logic busy;
    logic [TW-1:0] wc;
  } see_top_s;

  see_top_s q_ff;
  see_top_s nxt_q;
  logic [7:0] arr_ff [2**MW];
  logic [7:0] arr_rd;
  logic f_iv;
  logic f_ir;
  logic f_ov;
  logic [7:0] f_od;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic wr_en;

  assign o_sda_o = q_ff.sdo;
  assign o_sda_oe = q_ff.oe;
  assign o_busy = q_ff.busy;
  assign arr_rd = arr_ff[q_ff.ptr];
  assign rise = q_ff.fscl & ~q_ff.pscl;
  assign fall = ~q_ff.fscl & q_ff.pscl;
  assign start = q_ff.pscl & q_ff.fscl & q_ff.psda & ~q_ff.fsda;
  assign stop = q_ff.pscl & q_ff.fscl & ~q_ff.psda & q_ff.fsda;
  // A protected write still drains the buffer, but nothing reaches the array.
  assign wr_en = q_ff.drain & f_ov & ~q_ff.wp_l;

  see_fifo #(.W(8), .D(BUF_DEPTH)) u_buf (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_in_valid(f_iv),
    .i_in_data(q_ff.sh),
    .o_in_ready(f_ir),
    .o_out_valid(f_ov),
    .o_out_data(f_od),
    .i_out_ready(q_ff.drain)
  );

  always_comb begin
    nxt_q = q_ff;
    f_iv = 1'b0;
    nxt_q.scl_s = {q_ff.scl_s[0], i_scl};
    nxt_q.sda_s = {q_ff.sda_s[0], i_sda_i};
    nxt_q.str1 = i_chip_address_straps;
    nxt_q.str2 = q_ff.str1;
    nxt_q.wp1 = i_wp;
    nxt_q.wp2 = q_ff.wp1;
    nxt_q.pscl = q_ff.fscl;
    nxt_q.psda = q_ff.fsda;
    // A level is accepted only after it has differed for more than the spike width.
    if (q_ff.scl_s[1] == q_ff.fscl) begin
      nxt_q.cscl = '0;
    end else if (q_ff.cscl == see_pkg::SPK_CYC) begin
      nxt_q.fscl = q_ff.scl_s[1];
      nxt_q.cscl = '0;
    end else begin
      nxt_q.cscl = q_ff.cscl + 4'h1;
    end
    if (q_ff.sda_s[1] == q_ff.fsda) begin
      nxt_q.csda = '0;
    end else if (q_ff.csda == see_pkg::SPK_CYC) begin
      nxt_q.fsda = q_ff.sda_s[1];
      nxt_q.csda = '0;
    end else begin
      nxt_q.csda = q_ff.csda + 4'h1;
    end

    // Output changes wait out the undefined part of the falling clock edge.
    if (q_ff.hcnt != '0) begin
      nxt_q.hcnt = q_ff.hcnt - 4'h1;
      if (q_ff.hcnt == 4'h1) begin
        nxt_q.oe = q_ff.pend;
      end
    end

    if (q_ff.drain) begin
      if (f_ov) begin
        nxt_q.wad[4:0] = q_ff.wad[4:0] + 5'h01;
      end else begin
        nxt_q.drain = 1'b0;
        if (!q_ff.wp_l) begin
          nxt_q.ptr = q_ff.wad;
        end
      end
    end
    if (q_ff.busy) begin
      nxt_q.wc = q_ff.wc - TW'(1);
      if (q_ff.wc == '0) begin
        nxt_q.busy = 1'b0;
      end
    end

    if (start) begin
      nxt_q.st = see_pkg::ST_CTRL;
      nxt_q.bitc = '0;
      nxt_q.ack_ph = 1'b0;
      nxt_q.oe = 1'b0;
      nxt_q.hcnt = '0;
    end else if (stop) begin
      nxt_q.st = see_pkg::ST_IDLE;
      nxt_q.oe = 1'b0;
      nxt_q.hcnt = '0;
      if (q_ff.st == see_pkg::ST_WDAT && f_ov) begin
        nxt_q.wp_l = q_ff.wp2;
        nxt_q.drain = 1'b1;
        if (!q_ff.wp2) begin
          nxt_q.busy = 1'b1;
          nxt_q.wc = TW'(TWC_CYC - 1);
        end
      end
    end else if (rise) begin
      if (q_ff.st == see_pkg::ST_RDAT) begin
        if (q_ff.ack_ph) begin
          nxt_q.mack = ~q_ff.fsda;
        end else begin
          nxt_q.bitc = q_ff.bitc + 4'h1;
        end
      end else if (q_ff.st != see_pkg::ST_IDLE && q_ff.st != see_pkg::ST_IGN && !q_ff.ack_ph) begin
        nxt_q.sh = {q_ff.sh[6:0], q_ff.fsda};
        nxt_q.bitc = q_ff.bitc + 4'h1;
      end
    end else if (fall && q_ff.st != see_pkg::ST_IDLE && q_ff.st != see_pkg::ST_IGN) begin
      if (q_ff.ack_ph) begin
        nxt_q.ack_ph = 1'b0;
        nxt_q.bitc = '0;
        nxt_q.pend = 1'b0;
        nxt_q.hcnt = see_pkg::HOLD_CYC;
        unique case (q_ff.st)
          see_pkg::ST_CTRL: nxt_q.st = q_ff.sh[0] ? see_pkg::ST_RDAT : see_pkg::ST_ADRH;
          see_pkg::ST_ADRH: nxt_q.st = see_pkg::ST_ADRL;
          see_pkg::ST_ADRL: nxt_q.st = see_pkg::ST_WDAT;
          see_pkg::ST_RDAT: nxt_q.st = q_ff.mack ? see_pkg::ST_RDAT : see_pkg::ST_IGN;
          default: nxt_q.st = q_ff.st;
        endcase
        if ((q_ff.st == see_pkg::ST_CTRL && q_ff.sh[0]) || (q_ff.st == see_pkg::ST_RDAT && q_ff.mack)) begin
          nxt_q.sh = arr_rd;
          nxt_q.ptr = q_ff.ptr + MW'(1);
          nxt_q.pend = ~arr_rd[7];
        end
      end else if (q_ff.bitc == see_pkg::BIT_LAST) begin
        nxt_q.ack_ph = 1'b1;
        nxt_q.bitc = '0;
        nxt_q.hcnt = see_pkg::HOLD_CYC;
        nxt_q.pend = 1'b1;
        unique case (q_ff.st)
          see_pkg::ST_CTRL: begin
            // The match is decided once here and the state keeps it to the next start or stop.
            if (q_ff.sh[7:4] != DEV_TYPE || q_ff.sh[3:1] != q_ff.str2 || q_ff.busy || q_ff.drain) begin
              nxt_q.st = see_pkg::ST_IGN;
              nxt_q.pend = 1'b0;
              nxt_q.hcnt = '0;
            end
          end
          see_pkg::ST_ADRH: nxt_q.ptr[12:8] = q_ff.sh[4:0];
          see_pkg::ST_ADRL: begin
            nxt_q.ptr[7:0] = q_ff.sh;
            nxt_q.wad = {q_ff.ptr[12:8], q_ff.sh};
          end
          see_pkg::ST_WDAT: begin
            // A full buffer refuses the byte with a missing acknowledge.
            f_iv = 1'b1;
            nxt_q.pend = f_ir;
          end
          see_pkg::ST_RDAT: begin
            nxt_q.pend = 1'b0;
            nxt_q.mack = 1'b0;
          end
          default: nxt_q.pend = 1'b0;
        endcase
      end else if (q_ff.st == see_pkg::ST_RDAT) begin
        nxt_q.sh = {q_ff.sh[6:0], 1'b0};
        nxt_q.pend = ~q_ff.sh[6];
        nxt_q.hcnt = see_pkg::HOLD_CYC;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      arr_ff[q_ff.wad] <= f_od;
    end
  end
endmodule

`default_nettype wire

// file: verification/see_chk.sv
// Port checks of the serial EEPROM bus slave.
`timescale 1ns/1ps
`default_nettype none
module see_chk #(
  parameter int TWC_CYC = see_pkg::TWC_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic [2:0] i_chip_address_straps,
  input wire logic i_wp,
  input wire logic o_busy
);
  logic [3:0] fall_cnt_ff;
  int busy_cnt_ff;
  // Cycles since the clock pin fell, saturating so that idle time never wraps.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      fall_cnt_ff <= 4'hf;
      busy_cnt_ff <= 0;
    end else begin
      fall_cnt_ff <= $fell(i_scl) ? 4'h0 : (fall_cnt_ff == 4'hf ? 4'hf : fall_cnt_ff + 4'h1);
      busy_cnt_ff <= o_busy ? busy_cnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_drive_low: assert property (
    o_sda_o == 1'b0) else $error("data driven high");
  a_out_hold: assert property (
    $fell(i_scl) |=> $stable(o_sda_oe) [*3]) else $error("output hold too short");
  a_out_valid: assert property (
    $changed(o_sda_oe) && !i_scl |-> fall_cnt_ff inside {[4'h2:4'h8]}) else $error("output change out of window");
  a_high_quiet: assert property (
    i_scl && $past(i_scl) |-> !$rose(o_sda_oe)) else $error("data pulled with clock high");
  a_start_release: assert property (
    $fell(i_sda_i) && i_scl && $past(i_scl) |-> ##[0:8] !o_sda_oe) else $error("line held after start");
  a_busy_len: assert property (
    $fell(o_busy) |-> busy_cnt_ff >= TWC_CYC - 1 && busy_cnt_ff <= TWC_CYC) else $error("write cycle length");
  a_busy_noack: assert property (
    o_busy |-> !o_sda_oe) else $error("acknowledge during write cycle");
  a_busy_begin: assert property (
    $rose(o_busy) |-> !i_wp && i_scl && i_sda_i) else $error("write cycle without stop");
endmodule
bind see_slave see_chk #(.TWC_CYC(TWC_CYC)) i_see_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl),
  .i_sda_i(i_sda_i), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_chip_address_straps(i_chip_address_straps),
  .i_wp(i_wp), .o_busy(o_busy));
`default_nettype wire

// file: verification/see_master.sv
// Bus master model that clocks the serial EEPROM slave.
`timescale 1ns/1ps
`default_nettype none
module see_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_low
);
  initial begin
    o_scl = 1'b1;
    o_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // The low phase is stretched to three half periods, as the slave may need 900 ns to present a bit.
  task automatic bitc(input logic b, output logic r);
    tick(9);
    o_low <= !b;
    tick(3);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl <= 1'b0;
  endtask
  task automatic start();
    tick(9);
    o_low <= 1'b0;
    tick(3);
    o_scl <= 1'b1;
    tick(4);
    o_low <= 1'b1;
    tick(4);
    o_scl <= 1'b0;
  endtask
  // One clock-long high pulse on the clock line while data is steady, which the slave must not count as a bit.
  task automatic spike();
    tick(10);
    o_scl <= 1'b1;
    tick(1);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    tick(9);
    o_low <= 1'b1;
    tick(3);
    o_scl <= 1'b1;
    tick(4);
    o_low <= 1'b0;
    tick(13);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitc(d[i], r);
    bitc(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitc(1'b1, d[i]);
    bitc(last, r);
  endtask
endmodule
`default_nettype wire

// file: verification/see_slave_tb.sv
// Self-checking testbench of the serial EEPROM bus slave.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t %h %h", $time, g, e); end end
module see_slave_tb;
  localparam int TWC = 200;
  localparam logic [3:0] DEVT = 4'h9; // Arbitrary type code.
  localparam logic [2:0] STRAP = 3'h5;
  logic i_clk, i_nrst, i_wp, scl, m_low, sda_o, sda_oe, busy;
  logic [2:0] straps;
  logic [7:0] d;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire logic sda = !(m_low || (sda_oe && !sda_o));
  see_slave #(.TWC_CYC(TWC), .DEV_TYPE(DEVT), .BUF_DEPTH(16)) i_see_slave (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_chip_address_straps(straps),
    .i_wp(i_wp), .o_busy(busy));
  see_master i_see_master (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_low(m_low));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = !i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic ctrl(input logic [2:0] cs, input logic rd, output logic ack);
    i_see_master.start();
    i_see_master.wbyte({DEVT, cs, rd}, ack);
  endtask
  task automatic point(input logic [12:0] a);
    logic a1, a2, a3;
    ctrl(STRAP, 1'b0, a1);
    i_see_master.wbyte({3'h0, a[12:8]}, a2);
    i_see_master.wbyte(a[7:0], a3);
    `CHK({a1, a2, a3}, 3'h7)
  endtask
  task automatic wait_busy(input logic lvl, input int n);
    for (int i = 0; i < n && busy !== lvl; i++) @(posedge i_clk);
    `CHK(busy, lvl)
  endtask
  task automatic check_rd(input logic [12:0] a, input int n, input logic [7:0] base);
    logic k;
    point(a);
    ctrl(STRAP, 1'b1, k);
    `CHK(k, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_see_master.rbyte(i == n - 1, d);
      `CHK(d, base + 8'(i))
    end
    i_see_master.stop();
  endtask
  task automatic t_select();
    logic ack;
    for (int c = 0; c < 8; c++) begin
      ctrl(3'(c), 1'b0, ack);
      `CHK(ack, c == STRAP)
      i_see_master.stop();
    end
    i_see_master.start();
    i_see_master.wbyte({~DEVT, STRAP, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_see_master.stop();
    straps <= 3'h2;
    ctrl(3'h2, 1'b0, ack);
    `CHK(ack, 1'b1)
    i_see_master.stop();
    straps <= STRAP;
  endtask
  // A clock spike between bytes must not shift the bits of the byte that follows.
  task automatic t_spike();
    logic a1, a2;
    point(13'h0005);
    i_see_master.spike();
    i_see_master.wbyte(8'h3c, a1);
    i_see_master.spike();
    i_see_master.wbyte(8'h3d, a2);
    `CHK({a1, a2}, 2'h3)
    i_see_master.stop();
    wait_busy(1'b1, 30);
    wait_busy(1'b0, TWC + 10);
    check_rd(13'h0005, 2, 8'h3c);
  endtask
  // Seventeen bytes overrun the 16-deep buffer; the last one must be refused.
  task automatic t_page();
    logic ack;
    point(13'h1ff0);
    for (int i = 0; i < 17; i++) begin
      i_see_master.wbyte(8'ha0 + 8'(i), ack);
      `CHK(ack, i < 16)
    end
    i_see_master.stop();
    wait_busy(1'b1, 30);
    i_wp <= 1'b1;
    ctrl(STRAP, 1'b0, ack);
    `CHK(ack, 1'b0)
    i_see_master.stop();
    wait_busy(1'b0, TWC + 10);
    i_wp <= 1'b0;
    check_rd(13'h1ff0, 16, 8'ha0);
  endtask
  task automatic t_protect();
    logic a1, a2;
    i_wp <= 1'b1;
    point(13'h1ff0);
    i_see_master.wbyte(8'h55, a1);
    i_see_master.wbyte(8'h56, a2);
    `CHK({a1, a2}, 2'h3)
    i_see_master.stop();
    i_wp <= 1'b0;
    repeat (30) @(posedge i_clk);
    `CHK(busy, 1'b0)
    check_rd(13'h1ff0, 2, 8'ha0);
  endtask
  initial begin
    i_nrst <= 1'b0;
    i_wp <= 1'b0;
    straps <= STRAP;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (10) @(posedge i_clk);
    t_select();
    t_page();
    t_protect();
    t_spike();
    finish_test();
  end
endmodule
`undef CHK
`default_nettype wire
